// ==== ctw_regs.sv ====
// Threshold and wake registers behind the serial port, with bit decision
`timescale 1ns/1ps
`default_nettype none
`include "ctw_cfg.svh"
module ctw_regs (
  input wire logic core_clk,
  input wire logic rst,
  input wire ctw_pkg::ctw_spi_pins_t spi_pins,
  output logic spi_miso,
  output logic spi_miso_oe_n,
  input wire logic power_down_pin_n,
  input wire logic code_is_32,
  input wire logic [6:0] match_count,
  input wire logic count_valid,
  output ctw_pkg::ctw_bit_dec_t bit_dec,
  output logic wake_irq,
  output logic serial_ready
);
  import ctw_pkg::*;

  localparam logic [7:0] READY_CYC = 8'(`CTW_WAKE_READY_CYC);

  logic ssn_s, sck_s, mosi_s, pd_n_s;
  logic sck_prev_q;
  logic [2:0] bit_cnt_q;
  logic [7:0] rx_q, tx_q;
  ctw_spi_st_t st_q;
  logic is_wr_q, inc_q;
  logic [5:0] addr_q;
  logic [6:0] thr_high_q, thr_low_q;
  logic wake_en_q, wake_flag_q;
  logic [7:0] ready_cnt_q;
  logic ready_q;
  logic sel, rise, fall, byte_done, cmd_done, data_done;
  logic rd_load, rd_clr, wr_en, wake_set;
  logic [7:0] rx_byte;
  logic [5:0] rd_addr;
  logic [7:0] rd_data;
  logic [6:0] code_len;

  // Pin inputs cross into the core clock
  ctw_sync #(.W(4), .RST(4'h8)) u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .din({spi_pins.ssn_n, spi_pins.sck, spi_pins.mosi, power_down_pin_n}),
    .dout({ssn_s, sck_s, mosi_s, pd_n_s})
  );

  // Read data for an address; unmapped and reserved bits read zero
  function automatic logic [7:0] rd_mux(input logic [5:0] a, input logic [6:0] hi,
                                        input logic [6:0] lo, input logic en,
                                        input logic flag);
    logic [7:0] d;
    d = 8'h00;
    if (a == `CTW_ADDR_THR_HIGH) begin
      d = {1'b0, hi};
    end else if (a == `CTW_ADDR_THR_LOW) begin
      d = {1'b0, lo};
    end else if (a == `CTW_ADDR_WAKE_EN) begin
      d = {7'h00, en};
    end else if (a == `CTW_ADDR_WAKE_STAT) begin
      d = {7'h00, flag};
    end
    return d;
  endfunction : rd_mux

  // Frame strobes; the port is deaf until the device is ready
  assign sel = ~ssn_s & ready_q;
  assign rise = sel & sck_s & ~sck_prev_q;
  assign fall = sel & ~sck_s & sck_prev_q;
  assign rx_byte = {rx_q[6:0], mosi_s};
  assign byte_done = rise & (bit_cnt_q == 3'h7);
  assign cmd_done = byte_done & (st_q == CTW_ST_CMD);
  assign data_done = byte_done & (st_q == CTW_ST_DATA);
  assign rd_load = (cmd_done & ~rx_byte[`CTW_CMD_WRITE_BIT]) | (data_done & ~is_wr_q);
  assign rd_addr = cmd_done ? rx_byte[5:0] : addr_q;
  assign rd_data = rd_mux(rd_addr, thr_high_q, thr_low_q, wake_en_q, wake_flag_q);
  assign rd_clr = rd_load & (rd_addr == `CTW_ADDR_WAKE_STAT);
  assign wr_en = data_done & is_wr_q;
  assign wake_set = pd_n_s & ~ready_q & (ready_cnt_q == READY_CYC - 8'h01);
  assign code_len = code_is_32 ? `CTW_CODE_LEN_SHORT : `CTW_CODE_LEN_LONG;

  // Clock edge history
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sck_prev_q <= 1'b0;
    end else begin
      sck_prev_q <= sck_s;
    end
  end

  // Bit counting, receive shift and frame phase
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bit_cnt_q <= 3'h0;
      rx_q <= 8'h00;
      st_q <= CTW_ST_CMD;
      is_wr_q <= 1'b0;
      inc_q <= 1'b0;
    end else if (!sel) begin
      bit_cnt_q <= 3'h0;
      st_q <= CTW_ST_CMD;
    end else if (rise) begin
      rx_q <= rx_byte;
      bit_cnt_q <= bit_cnt_q + 3'h1;
      if (cmd_done) begin
        st_q <= CTW_ST_DATA;
        is_wr_q <= rx_byte[`CTW_CMD_WRITE_BIT];
        inc_q <= rx_byte[`CTW_CMD_INC_BIT];
      end
    end
  end

  // Address pointer with optional auto-increment
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      addr_q <= 6'h00;
    end else if (cmd_done) begin
      addr_q <= rx_byte[5:0] + {5'h00, ~rx_byte[`CTW_CMD_WRITE_BIT] & rx_byte[`CTW_CMD_INC_BIT]};
    end else if (data_done && inc_q) begin
      addr_q <= addr_q + 6'h01;
    end
  end

  // Transmit shift; first bit loaded on the last rising edge of the prior byte, rest on falling edges
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tx_q <= 8'h00;
      spi_miso <= 1'b0;
      spi_miso_oe_n <= 1'b1;
    end else if (!sel) begin
      tx_q <= 8'h00;
      spi_miso <= 1'b0;
      spi_miso_oe_n <= 1'b1;
    end else begin
      spi_miso_oe_n <= 1'b0;
      if (rd_load) begin
        spi_miso <= rd_data[7];
        tx_q <= {rd_data[6:0], 1'b0};
      end else if (fall && bit_cnt_q != 3'h0) begin
        spi_miso <= tx_q[7];
        tx_q <= {tx_q[6:0], 1'b0};
      end
    end
  end

  // Writable fields; reserved bits dropped, wake status never written
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      thr_high_q <= `CTW_THR_HIGH_RST;
      thr_low_q <= `CTW_THR_LOW_RST;
      wake_en_q <= `CTW_WAKE_EN_RST;
    end else if (wr_en) begin
      if (addr_q == `CTW_ADDR_THR_HIGH) begin
        thr_high_q <= rx_byte[6:0];
      end else if (addr_q == `CTW_ADDR_THR_LOW) begin
        thr_low_q <= rx_byte[6:0];
      end else if (addr_q == `CTW_ADDR_WAKE_EN) begin
        wake_en_q <= rx_byte[0];
      end
    end
  end

  // Power-down release timer; ready once it expires
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ready_cnt_q <= 8'h00;
      ready_q <= 1'b0;
    end else if (!pd_n_s) begin
      ready_cnt_q <= 8'h00;
      ready_q <= 1'b0;
    end else if (!ready_q) begin
      ready_cnt_q <= ready_cnt_q + 8'h01;
      ready_q <= wake_set;
    end
  end

  // Pending wake flag; a new wake beats a clearing read
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wake_flag_q <= `CTW_WAKE_STAT_RST;
    end else if (wake_set) begin
      wake_flag_q <= 1'b1;
    end else if (rd_clr) begin
      wake_flag_q <= 1'b0;
    end
  end

  // Interrupt and ready outputs
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wake_irq <= 1'b0;
      serial_ready <= 1'b0;
    end else begin
      wake_irq <= wake_flag_q & wake_en_q;
      serial_ready <= ready_q;
    end
  end

  // Bit decision from match count; one has priority over zero
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bit_dec <= '0;
    end else if (count_valid && match_count <= code_len) begin
      bit_dec.valid <= (match_count >= thr_high_q) | (match_count <= thr_low_q);
      bit_dec.one <= match_count >= thr_high_q;
      bit_dec.erasure <= (match_count < thr_high_q) & (match_count > thr_low_q);
    end else begin
      bit_dec.valid <= 1'b0;
      bit_dec.one <= 1'b0;
      bit_dec.erasure <= count_valid;
    end
  end

  property p_one_decide;
    @(posedge core_clk) disable iff (rst)
    count_valid && match_count <= code_len && match_count >= thr_high_q
      |=> bit_dec.valid && bit_dec.one;
  endproperty
  a_one_decide: assert property (p_one_decide) else $error("one not decided");

  property p_zero_decide;
    @(posedge core_clk) disable iff (rst)
    count_valid && match_count <= code_len && match_count <= thr_low_q &&
      match_count < thr_high_q |=> bit_dec.valid && !bit_dec.one && !bit_dec.erasure;
  endproperty
  a_zero_decide: assert property (p_zero_decide) else $error("zero not decided");

  property p_band;
    @(posedge core_clk) disable iff (rst)
    count_valid && match_count > thr_low_q && match_count < thr_high_q
      |=> !bit_dec.valid && bit_dec.erasure;
  endproperty
  a_band: assert property (p_band) else $error("mid count not an erasure");

  property p_code_len;
    @(posedge core_clk) disable iff (rst)
    count_valid && match_count > (code_is_32 ? 7'h20 : 7'h40) |=> !bit_dec.valid;
  endproperty
  a_code_len: assert property (p_code_len) else $error("count beyond code length");

  property p_thr_rst;
    @(posedge core_clk) disable iff (rst)
    $fell(rst) |-> thr_high_q == 7'h38;
  endproperty
  a_thr_rst: assert property (p_thr_rst) else $error("upper threshold reset wrong");

  property p_wake_ready;
    @(posedge core_clk) disable iff (rst)
    $rose(ready_q) |-> (wake_flag_q && $past(pd_n_s, 1)) ##1 serial_ready;
  endproperty
  a_wake_ready: assert property (p_wake_ready) else $error("wake not raised at ready");

  property p_wake_clear;
    @(posedge core_clk) disable iff (rst)
    rd_clr && !wake_set |=> !wake_flag_q ##1 !wake_irq;
  endproperty
  a_wake_clear: assert property (p_wake_clear) else $error("read did not clear wake");

  property p_stat_ro;
    @(posedge core_clk) disable iff (rst)
    wr_en && addr_q == `CTW_ADDR_WAKE_STAT && !wake_set |=> $stable(wake_flag_q);
  endproperty
  a_stat_ro: assert property (p_stat_ro) else $error("wake status written");

  property p_irq;
    @(posedge core_clk) disable iff (rst)
    wake_flag_q && wake_en_q |=> wake_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("wake irq missing");

  property p_irq_gate;
    @(posedge core_clk) disable iff (rst)
    ##1 wake_irq |-> $past(wake_flag_q) && $past(wake_en_q);
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("wake irq without cause");

  c_stat_read: cover property (@(posedge core_clk) disable iff (rst) rd_clr ##1 !wake_flag_q);
  c_one_bit: cover property (@(posedge core_clk) disable iff (rst) bit_dec.valid && bit_dec.one);
  c_thr_write: cover property (@(posedge core_clk) disable iff (rst)
    wr_en && addr_q == `CTW_ADDR_THR_HIGH);

endmodule : ctw_regs
`default_nettype wire

// ==== ctw_cfg.svh ====
// Offsets, field positions, reset values and timing counts of the threshold and wake slice
// How it works
// - Upper threshold bits 6 to 0 give the match count that decides a one.
// - A clean one gives matches equal to code length, 64 or 32.
// - Upper threshold resets to 0x38, code length less eight.
// - Upper and lower thresholds together bound the counts for one and zero.
// - Wake event is raised after power-down release, once serial access is ready.
// - Wake status bit 0 reads one while a wake is pending; wake sets it.
// - A host read of wake status at 0x1D clears the pending flag.
// - Wake status is read-only; host writes change nothing.
// - Lower threshold bits 6 to 0 give allowed missed chips for a zero.
// - Spreading code runs as one 64-chip or two 32-chip codes.
`ifndef CTW_CFG_SVH
`define CTW_CFG_SVH

// Register offsets on the serial port
`define CTW_ADDR_THR_LOW 6'h19
`define CTW_ADDR_THR_HIGH 6'h1A
`define CTW_ADDR_WAKE_EN 6'h1C
`define CTW_ADDR_WAKE_STAT 6'h1D

// Reset values
`define CTW_THR_LOW_RST 7'h08
`define CTW_THR_HIGH_RST 7'h38
`define CTW_WAKE_EN_RST 1'b0
`define CTW_WAKE_STAT_RST 1'b1

// Command byte fields
`define CTW_CMD_WRITE_BIT 7
`define CTW_CMD_INC_BIT 6

// Spreading code lengths in chips
`define CTW_CODE_LEN_LONG 7'h40
`define CTW_CODE_LEN_SHORT 7'h20

// Time from power-down release to serial readiness
`define CTW_CLK_PERIOD_NS 100
`define CTW_WAKE_READY_NS 1000
`define CTW_WAKE_READY_CYC \
  ((`CTW_WAKE_READY_NS + `CTW_CLK_PERIOD_NS - 1) / `CTW_CLK_PERIOD_NS)

`endif

// ==== ctw_pkg.sv ====
// Types shared by the threshold and wake slice
package ctw_pkg;

  // Serial pins as sampled from the host
  typedef struct packed {
    logic ssn_n;
    logic sck;
    logic mosi;
  } ctw_spi_pins_t;

  // Outcome of one correlated data bit
  typedef struct packed {
    logic valid;
    logic one;
    logic erasure;
  } ctw_bit_dec_t;

  // Serial frame phase
  typedef enum logic {
    CTW_ST_CMD,
    CTW_ST_DATA
  } ctw_spi_st_t;

endpackage : ctw_pkg

// ==== ctw_sync.sv ====
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module ctw_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  logic [W-1:0] meta_q;

  // First stage feeds only the second
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      meta_q <= RST;
      dout <= RST;
    end else begin
      meta_q <= din;
      dout <= meta_q;
    end
  end

endmodule : ctw_sync
`default_nettype wire

// ==== ctw_host.sv ====
// Host model driving the serial register port in mode 0
`timescale 1ns/1ps
`default_nettype none
module ctw_host (
  input wire logic core_clk,
  input wire logic spi_miso,
  output ctw_pkg::ctw_spi_pins_t spi_pins,
  output logic [7:0] rd_byte,
  output logic rd_done
);
  import ctw_pkg::*;

  // Idle: deselected, clock parked low
  initial begin
    spi_pins = '{ssn_n: 1'b1, sck: 1'b0, mosi: 1'b0};
    rd_byte = 8'h00;
    rd_done = 1'b0;
  end

  // Select or release; released data line shows the inverse of its last bit
  task automatic sel(input logic on);
    @(posedge core_clk);
    spi_pins.ssn_n <= !on;
    if (!on) spi_pins.mosi <= !spi_pins.mosi;
    repeat (8) @(posedge core_clk);
  endtask : sel

  // One byte MSB first, 800 ns per bit; data read mid high phase
  task automatic xfer(input logic [7:0] tx, input logic show);
    logic [7:0] rx;
    for (int i = 7; i >= 0; i--) begin
      @(posedge core_clk);
      spi_pins.sck <= 1'b0;
      spi_pins.mosi <= tx[i];
      repeat (4) @(posedge core_clk);
      spi_pins.sck <= 1'b1;
      repeat (2) @(posedge core_clk);
      rx[i] = spi_miso;
      @(posedge core_clk);
    end
    @(posedge core_clk);
    spi_pins.sck <= 1'b0;
    if (show) begin
      rd_byte <= rx;
      rd_done <= 1'b1;
    end
    @(posedge core_clk);
    rd_done <= 1'b0;
  endtask : xfer
endmodule : ctw_host
`default_nettype wire

// ==== ctw_tb.sv ====
// Self-checking bench for the threshold and wake register slice
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ctw_pkg::*;
  logic core_clk = 1'b0;
  logic rst;
  logic power_down_pin_n;
  logic code_is_32;
  logic count_valid;
  logic [6:0] match_count;
  ctw_spi_pins_t spi_pins;
  ctw_bit_dec_t bit_dec;
  logic spi_miso, spi_miso_oe_n, wake_irq, serial_ready, rd_done, cv_q;
  logic [7:0] rd_byte;
  logic [15:0] exp_q[$];
  logic [15:0] e;
  logic [31:0] lfsr_s = 32'h0001_12c7;
  logic [6:0] hi, lo, len;
  logic [6:0] cands[6];
  int n_mismatch = 0;
  int tests_run = 0;

  // 10 MHz clock
  always #50 core_clk = ~core_clk;

  ctw_regs dut (.core_clk(core_clk), .rst(rst), .spi_pins(spi_pins), .spi_miso(spi_miso),
    .spi_miso_oe_n(spi_miso_oe_n), .power_down_pin_n(power_down_pin_n),
    .code_is_32(code_is_32), .match_count(match_count), .count_valid(count_valid),
    .bit_dec(bit_dec), .wake_irq(wake_irq), .serial_ready(serial_ready));
  ctw_host host (.core_clk(core_clk), .spi_miso(spi_miso), .spi_pins(spi_pins),
    .rd_byte(rd_byte), .rd_done(rd_done));

  // Next value of the stimulus shift register
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test

  // Watcher: oldest note against each read byte or bit decision
  always @(posedge core_clk) begin
    cv_q <= count_valid;
    if (rd_done) begin
      e = exp_q.pop_front();
      check(rd_byte & e[15:8], e[7:0]);
    end
    if (cv_q) begin
      e = exp_q.pop_front();
      check({5'h00, bit_dec} & e[15:8], e[7:0]);
    end
  end

  task automatic rd1(input logic [5:0] a, input logic [7:0] ex);
    exp_q.push_back({8'hff, ex});
    host.sel(1'b1);
    check({7'h00, spi_miso_oe_n}, 8'h00);
    host.xfer({2'b00, a}, 1'b0);
    host.xfer(8'h00, 1'b1);
    host.sel(1'b0);
    check({6'h00, spi_miso_oe_n, spi_miso}, 8'h02);
  endtask : rd1

  task automatic wr1(input logic [5:0] a, input logic [7:0] d);
    host.sel(1'b1);
    host.xfer({2'b10, a}, 1'b0);
    host.xfer(d, 1'b0);
    host.sel(1'b0);
  endtask : wr1

  task automatic wait_rdy();
    for (int i = 0; i < 40 && serial_ready !== 1'b1; i++) @(posedge core_clk);
    check({7'h00, serial_ready}, 8'h01);
  endtask : wait_rdy

  // One count; expectation as {mask, value} over valid, one, erasure
  task automatic dec(input logic [6:0] c, input logic s32);
    len = s32 ? 7'h20 : 7'h40;
    if (c > len) exp_q.push_back({8'h07, 8'h01});
    else if (c >= hi) exp_q.push_back({8'h07, 8'h06});
    else if (c <= lo) exp_q.push_back({8'h07, 8'h04});
    else exp_q.push_back({8'h07, 8'h01});
    @(posedge core_clk);
    code_is_32 <= s32;
    match_count <= c;
    count_valid <= 1'b1;
    @(posedge core_clk);
    count_valid <= 1'b0;
  endtask : dec

  task automatic pwr_cycle();
    @(posedge core_clk);
    power_down_pin_n <= 1'b0;
    repeat (20) @(posedge core_clk);
    check({6'h00, serial_ready, wake_irq}, 8'h00);
    power_down_pin_n <= 1'b1;
    wait_rdy();
  endtask : pwr_cycle

  initial begin
    rst <= 1'b1;
    power_down_pin_n <= 1'b1;
    code_is_32 <= 1'b0;
    count_valid <= 1'b0;
    match_count <= 7'h00;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    wait_rdy();
    // Reset values by auto-increment read 0x1A..0x1D, 0x1B unmapped
    exp_q.push_back({8'hff, 8'h38});
    exp_q.push_back({8'hff, 8'h00});
    exp_q.push_back({8'hff, 8'h00});
    exp_q.push_back({8'hff, 8'h01});
    host.sel(1'b1);
    host.xfer(8'h5a, 1'b0);
    repeat (4) host.xfer(8'h00, 1'b1);
    host.sel(1'b0);
    check({7'h00, wake_irq}, 8'h00);
    rd1(6'h1d, 8'h00);
    wr1(6'h1d, 8'hff);
    rd1(6'h1d, 8'h00);
    // Random thresholds, top bit written as zero
    lfsr_s = lfsr_next(lfsr_s);
    hi = 7'h18 + {2'b00, lfsr_s[4:0]};
    lo = {4'h0, lfsr_s[10:8]};
    // Both thresholds in one auto-increment write frame from 0x19
    host.sel(1'b1);
    host.xfer(8'hd9, 1'b0);
    host.xfer({1'b0, lo}, 1'b0);
    host.xfer({1'b0, hi}, 1'b0);
    host.sel(1'b0);
    rd1(6'h1a, {1'b0, hi});
    rd1(6'h19, {1'b0, lo});
    // Boundary and random counts for both code lengths
    for (int k = 0; k < 2; k++) begin
      len = k[0] ? 7'h20 : 7'h40;
      cands = '{hi, hi - 7'd1, lo, lo + 7'd1, len, len + 7'd1};
      for (int j = 0; j < 6; j++) dec(cands[j], k[0]);
      for (int j = 0; j < 8; j++) begin
        lfsr_s = lfsr_next(lfsr_s);
        dec(lfsr_s[6:0], k[0]);
      end
    end
    // Wake enabled: flag and interrupt come back at readiness
    wr1(6'h1c, 8'h01);
    pwr_cycle();
    check({7'h00, wake_irq}, 8'h01);
    rd1(6'h1d, 8'h01);
    repeat (2) @(posedge core_clk);
    check({7'h00, wake_irq}, 8'h00);
    // Wake disabled: flag sets, interrupt stays low
    wr1(6'h1c, 8'h00);
    pwr_cycle();
    repeat (2) @(posedge core_clk);
    check({7'h00, wake_irq}, 8'h00);
    rd1(6'h1d, 8'h01);
    repeat (5) @(posedge core_clk);
    check(8'(exp_q.size()), 8'h00);
    stop_test();
  end

  // Watchdog well beyond the expected run
  initial begin
    #2_000_000;
    n_mismatch++;
    stop_test();
  end
endmodule : tb
`default_nettype wire
